/* File: atc_pkg.sv */
// Purpose: shared constants for the audio path and tone control bank
// Assumes: 8-bit registers reached over the serial control port
// Notes:   instruction byte = power, 4-bit address, read, second byte

package atc_pkg;

    // register addresses carried in the instruction byte
    localparam logic [3:0] ADDR_PATH  = 4'h4;
    localparam logic [3:0] ADDR_GAIN  = 4'h5;
    localparam logic [3:0] ADDR_ATTEN = 4'h6;
    localparam logic [3:0] ADDR_TONE  = 4'h7;
    localparam logic [3:0] ADDR_FREQ1 = 4'h8;
    localparam logic [3:0] ADDR_FREQ2 = 4'h9;

    // instruction byte field positions
    localparam int INS_POWER_BIT  = 7;
    localparam int INS_ADDR_MSB   = 6;
    localparam int INS_ADDR_LSB   = 3;
    localparam int INS_READ_BIT   = 2;
    localparam int INS_SECOND_BIT = 1;

    // path register field positions
    localparam int PATH_TX_HI_BIT  = 7;
    localparam int PATH_TX_LO_BIT  = 6;
    localparam int PATH_SIDE_BIT   = 5;
    localparam int PATH_RX_HI_BIT  = 4;
    localparam int PATH_RX_LO_BIT  = 3;
    localparam int PATH_RING_BIT   = 2;
    localparam int PATH_HPF_BIT    = 1;
    localparam int PATH_RXSIG_BIT  = 0;

    // tone control field positions
    localparam int TONE_FIRST_BIT  = 3;
    localparam int TONE_SECOND_BIT = 2;
    localparam int TONE_SINE_BIT   = 1;
    localparam int TONE_TX_BIT     = 0;

    // forbidden receive route code
    localparam logic [1:0] ROUTE_FORBIDDEN = 2'h3;

    // reset values and the value read back from unmapped addresses
    localparam logic [7:0] REG_RST        = 8'h00;
    localparam logic       POWER_DOWN_RST = 1'b1;
    localparam logic [7:0] UNMAPPED_READ  = 8'h00;

    // serial framing
    localparam logic [3:0] LAST_BIT = 4'h7;

    // serial sequencer states
    typedef enum logic [1:0] {
        ATC_INSTR   = 2'b00,
        ATC_DATA_WR = 2'b01,
        ATC_DATA_RD = 2'b10,
        ATC_DONE    = 2'b11
    } atc_state_e;

endpackage

/* File: atc_shift8.sv */
// Purpose: 8-bit shift register for the serial control port
// Assumes: load has priority over shift
// Notes:   shifts msb first, new bit enters at bit 0

`timescale 1ns/100ps
`default_nettype none

module atc_shift8
(
    // clock and reset
    input  wire logic       clk,
    input  wire logic       rst_b,
    // control
    input  wire logic       load,
    input  wire logic [7:0] load_val,
    input  wire logic       shift,
    input  wire logic       ser_in,
    // contents
    output logic      [7:0] q
);

    logic [7:0] next_q;

    // parallel load for read-back, serial shift otherwise
    always_comb
    begin
        next_q = q;
        if (load)
        begin
            next_q = load_val;
        end
        else if (shift)
        begin
            next_q = {q[6:0], ser_in};
        end
    end

    // register the contents
    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            q <= atc_pkg::REG_RST;
        end
        else
        begin
            q <= next_q;
        end
    end

endmodule

`default_nettype wire

/* File: atc_tone_ctrl_regs.sv */
// Purpose: audio path and tone generator control bank, serial port
// Assumes: sclk, cs_b and ci are synchronous to clk, sclk well below it
// Notes:   data in sampled on sclk rise, data out changes on sclk fall
//
// Behaviour
// - path bits 7:6 pick transmit input: mute or one of three mics.
// - path bit 5 enables internal sidetone; resets disabled.
// - path bits 4:3 route receive output; code 11 never used; reset mute.
// - path bit 2 lets ring or tone onto the receive output; resets blocked.
// - path bit 1 set bypasses the receive high-pass filter; resets active.
// - path bit 0 passes decoded receive signal to the selected output.
// - gain upper nibble sets transmit gain, 1.5 dB per code, reset 0 dB.
// - gain lower nibble sets sidetone gain, -12.5 dB down 1 dB per code.
// - attenuation upper nibble sets earpiece gain, -2 dB per code.
// - attenuation lower nibble sets auxiliary gain, -2 dB per code.
// - tone upper nibble sets tone attenuation, 3 dB steps, reset 0 dB.
// - tone bits 3:2 choose first, second, both or no frequencies.
// - tone bit 1 selects sine when set, square when clear.
// - tone bit 0 injects the tone generator into the transmit path.
// - first frequency register holds an unsigned 8-bit word, msb bit 7.
// - second frequency register holds an unsigned 8-bit word, msb bit 7.
// - bit 7 of instruction and data bytes is shifted first.
// - instruction bit 2 selects read-back instead of write.
// - every instruction carries a power bit; one powers down, zero up.

`timescale 1ns/100ps
`default_nettype none

module atc_tone_ctrl_regs
(
    // clock and reset
    input  wire logic       clk,
    input  wire logic       rst_b,
    // serial control port
    input  wire logic       sclk,
    input  wire logic       cs_b,
    input  wire logic       ci,
    output logic            co,
    output logic            co_oe_b,
    // power control
    output logic            power_down,
    // audio path selection
    output logic            tx_input_sel_hi,
    output logic            tx_input_sel_lo,
    output logic            sidetone_on,
    output logic            rx_out_sel_hi,
    output logic            rx_out_sel_lo,
    output logic            ring_to_output_on,
    output logic            rx_highpass_bypass,
    output logic            rx_signal_to_output_on,
    // amplifier gains
    output logic      [3:0] tx_amp_gain,
    output logic      [3:0] sidetone_gain,
    output logic      [3:0] earpiece_gain,
    output logic      [3:0] aux_amp_gain,
    // tone generator
    output logic      [3:0] tone_atten,
    output logic            first_freq_select,
    output logic            second_freq_select,
    output logic            sine_select,
    output logic            tone_into_tx,
    output logic      [7:0] first_freq_word,
    output logic      [7:0] second_freq_word
);

    // sequencer state
    atc_pkg::atc_state_e state;
    atc_pkg::atc_state_e next_state;
    logic [3:0]          bit_cnt;
    logic [3:0]          next_bit_cnt;
    logic [3:0]          addr_q;
    logic [3:0]          next_addr_q;
    logic                sclk_q;
    logic                next_co;
    logic                next_co_oe_b;
    logic                next_power_down;

    // register bank
    logic [7:0] audio_path_select;
    logic [7:0] tx_and_sidetone_gain;
    logic [7:0] output_amp_attenuation;
    logic [7:0] tone_generator_control;
    logic [7:0] tone_freq_one;
    logic [7:0] tone_freq_two;
    logic [7:0] next_path;
    logic [7:0] next_gain;
    logic [7:0] next_atten;
    logic [7:0] next_tone;
    logic [7:0] next_freq1;
    logic [7:0] next_freq2;

    // shifter control and decoded events
    logic       sclk_rise;
    logic       sclk_fall;
    logic [7:0] shift_q;
    logic [7:0] rx_byte;
    logic [3:0] rd_addr;
    logic [7:0] read_val;
    logic       sh_load;
    logic       sh_shift;
    logic       instr_done;
    logic       rd_load;
    logic       wr_commit;

    // sclk edges; inputs are already in the clk domain
    assign sclk_rise = sclk & ~sclk_q;
    assign sclk_fall = ~sclk & sclk_q;

    // byte as it stands once the current rising edge is taken in
    assign rx_byte = {shift_q[6:0], ci};
    assign rd_addr = rx_byte[atc_pkg::INS_ADDR_MSB:atc_pkg::INS_ADDR_LSB];

    // read-back source; addresses outside the bank read as zero
    always_comb
    begin
        case (rd_addr)
            atc_pkg::ADDR_PATH:  read_val = audio_path_select;
            atc_pkg::ADDR_GAIN:  read_val = tx_and_sidetone_gain;
            atc_pkg::ADDR_ATTEN: read_val = output_amp_attenuation;
            atc_pkg::ADDR_TONE:  read_val = tone_generator_control;
            atc_pkg::ADDR_FREQ1: read_val = tone_freq_one;
            atc_pkg::ADDR_FREQ2: read_val = tone_freq_two;
            default:             read_val = atc_pkg::UNMAPPED_READ;
        endcase
    end

    // one shift register serves both directions of the port
    atc_shift8 u_shift
    (
        .clk      (clk),
        .rst_b    (rst_b),
        .load     (sh_load),
        .load_val (read_val),
        .shift    (sh_shift),
        .ser_in   (ci),
        .q        (shift_q)
    );

    // serial sequencer: instruction byte, optional data byte
    always_comb
    begin
        next_state      = state;
        next_bit_cnt    = bit_cnt;
        next_addr_q     = addr_q;
        next_co         = co;
        next_co_oe_b    = co_oe_b;
        next_power_down = power_down;
        sh_load         = 1'b0;
        sh_shift        = 1'b0;
        instr_done      = 1'b0;
        rd_load         = 1'b0;
        wr_commit       = 1'b0;
        if (cs_b)
        begin
            // deselect aborts any partial frame and frees the data pin
            next_state   = atc_pkg::ATC_INSTR;
            next_bit_cnt = 4'h0;
            next_co_oe_b = 1'b1;
        end
        else
        begin
            case (state)
                atc_pkg::ATC_INSTR:
                begin
                    if (sclk_rise)
                    begin
                        sh_shift     = 1'b1;
                        next_bit_cnt = bit_cnt + 4'h1;
                        if (bit_cnt == atc_pkg::LAST_BIT)
                        begin
                            instr_done      = 1'b1;
                            next_bit_cnt    = 4'h0;
                            next_addr_q     = rd_addr;
                            next_power_down =
                                rx_byte[atc_pkg::INS_POWER_BIT];
                            if (!rx_byte[atc_pkg::INS_SECOND_BIT])
                            begin
                                next_state = atc_pkg::ATC_DONE;
                            end
                            else if (rx_byte[atc_pkg::INS_READ_BIT])
                            begin
                                // load replaces the shift this edge
                                sh_shift   = 1'b0;
                                sh_load    = 1'b1;
                                rd_load    = 1'b1;
                                next_state = atc_pkg::ATC_DATA_RD;
                            end
                            else
                            begin
                                next_state = atc_pkg::ATC_DATA_WR;
                            end
                        end
                    end
                end
                atc_pkg::ATC_DATA_WR:
                begin
                    if (sclk_rise)
                    begin
                        sh_shift     = 1'b1;
                        next_bit_cnt = bit_cnt + 4'h1;
                        if (bit_cnt == atc_pkg::LAST_BIT)
                        begin
                            wr_commit  = 1'b1;
                            next_state = atc_pkg::ATC_DONE;
                        end
                    end
                end
                atc_pkg::ATC_DATA_RD:
                begin
                    // drive on the fall so the host samples a settled bit
                    if (sclk_fall)
                    begin
                        next_co      = shift_q[7];
                        next_co_oe_b = 1'b0;
                        sh_shift     = 1'b1;
                    end
                    if (sclk_rise)
                    begin
                        next_bit_cnt = bit_cnt + 4'h1;
                        if (bit_cnt == atc_pkg::LAST_BIT)
                        begin
                            next_state = atc_pkg::ATC_DONE;
                        end
                    end
                end
                atc_pkg::ATC_DONE:
                begin
                    // extra clocks are ignored until deselect
                    next_bit_cnt = 4'h0;
                end
                default:
                begin
                    next_state = atc_pkg::ATC_INSTR;
                end
            endcase
        end
    end

    // sequencer registers
    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            state      <= atc_pkg::ATC_INSTR;
            bit_cnt    <= 4'h0;
            addr_q     <= 4'h0;
            sclk_q     <= 1'b0;
            co         <= 1'b0;
            co_oe_b    <= 1'b1;
            power_down <= atc_pkg::POWER_DOWN_RST;
        end
        else
        begin
            state      <= next_state;
            bit_cnt    <= next_bit_cnt;
            addr_q     <= next_addr_q;
            sclk_q     <= sclk;
            co         <= next_co;
            co_oe_b    <= next_co_oe_b;
            power_down <= next_power_down;
        end
    end

    // register bank writes, decoded by the latched address
    always_comb
    begin
        next_path  = audio_path_select;
        next_gain  = tx_and_sidetone_gain;
        next_atten = output_amp_attenuation;
        next_tone  = tone_generator_control;
        next_freq1 = tone_freq_one;
        next_freq2 = tone_freq_two;
        if (wr_commit)
        begin
            case (addr_q)
                atc_pkg::ADDR_PATH:
                begin
                    next_path = rx_byte;
                    // a forbidden route keeps the previous routing
                    if (rx_byte[atc_pkg::PATH_RX_HI_BIT:
                                atc_pkg::PATH_RX_LO_BIT]
                        == atc_pkg::ROUTE_FORBIDDEN)
                    begin
                        next_path[atc_pkg::PATH_RX_HI_BIT:
                                  atc_pkg::PATH_RX_LO_BIT] =
                            audio_path_select[atc_pkg::PATH_RX_HI_BIT:
                                              atc_pkg::PATH_RX_LO_BIT];
                    end
                end
                atc_pkg::ADDR_GAIN:  next_gain  = rx_byte;
                atc_pkg::ADDR_ATTEN: next_atten = rx_byte;
                atc_pkg::ADDR_TONE:  next_tone  = rx_byte;
                atc_pkg::ADDR_FREQ1: next_freq1 = rx_byte;
                atc_pkg::ADDR_FREQ2: next_freq2 = rx_byte;
                default:             next_path  = audio_path_select;
            endcase
        end
    end

    // register bank flops, all clear at reset
    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            audio_path_select      <= atc_pkg::REG_RST;
            tx_and_sidetone_gain   <= atc_pkg::REG_RST;
            output_amp_attenuation <= atc_pkg::REG_RST;
            tone_generator_control <= atc_pkg::REG_RST;
            tone_freq_one          <= atc_pkg::REG_RST;
            tone_freq_two          <= atc_pkg::REG_RST;
        end
        else
        begin
            audio_path_select      <= next_path;
            tx_and_sidetone_gain   <= next_gain;
            output_amp_attenuation <= next_atten;
            tone_generator_control <= next_tone;
            tone_freq_one          <= next_freq1;
            tone_freq_two          <= next_freq2;
        end
    end

    // path fields; analog blocks decode the codes themselves
    assign tx_input_sel_hi =
        audio_path_select[atc_pkg::PATH_TX_HI_BIT];
    assign tx_input_sel_lo =
        audio_path_select[atc_pkg::PATH_TX_LO_BIT];
    assign sidetone_on =
        audio_path_select[atc_pkg::PATH_SIDE_BIT];
    assign rx_out_sel_hi =
        audio_path_select[atc_pkg::PATH_RX_HI_BIT];
    assign rx_out_sel_lo =
        audio_path_select[atc_pkg::PATH_RX_LO_BIT];
    assign ring_to_output_on =
        audio_path_select[atc_pkg::PATH_RING_BIT];
    assign rx_highpass_bypass =
        audio_path_select[atc_pkg::PATH_HPF_BIT];
    assign rx_signal_to_output_on =
        audio_path_select[atc_pkg::PATH_RXSIG_BIT];

    // gain and attenuation nibbles, codes passed through unchanged
    assign tx_amp_gain   = tx_and_sidetone_gain[7:4];
    assign sidetone_gain = tx_and_sidetone_gain[3:0];
    assign earpiece_gain = output_amp_attenuation[7:4];
    assign aux_amp_gain  = output_amp_attenuation[3:0];

    // tone generator fields; codes above the defined range pass as written
    assign tone_atten = tone_generator_control[7:4];
    assign first_freq_select =
        tone_generator_control[atc_pkg::TONE_FIRST_BIT];
    assign second_freq_select =
        tone_generator_control[atc_pkg::TONE_SECOND_BIT];
    assign sine_select =
        tone_generator_control[atc_pkg::TONE_SINE_BIT];
    assign tone_into_tx =
        tone_generator_control[atc_pkg::TONE_TX_BIT];
    assign first_freq_word  = tone_freq_one;
    assign second_freq_word = tone_freq_two;

    // checks on the bank and the port
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_b);

    path_write_a: assert property (
        wr_commit && addr_q == atc_pkg::ADDR_PATH
        && rx_byte[4:3] != atc_pkg::ROUTE_FORBIDDEN
        |=> audio_path_select == $past(rx_byte))
        else $error("path register did not take written value");

    reset_values_a: assert property (
        $rose(rst_b) |-> audio_path_select == 8'h00
        && tx_and_sidetone_gain == 8'h00 && tone_generator_control == 8'h00
        && output_amp_attenuation == 8'h00 && power_down && co_oe_b)
        else $error("bank not at reset values after reset");

    route_legal_a: assert property (
        !(rx_out_sel_hi && rx_out_sel_lo))
        else $error("forbidden receive route stored");

    gain_write_a: assert property (
        wr_commit && addr_q == atc_pkg::ADDR_GAIN
        |=> tx_amp_gain == $past(rx_byte[7:4])
        && sidetone_gain == $past(rx_byte[3:0]))
        else $error("gain nibbles not updated");

    tone_write_a: assert property (
        wr_commit && addr_q == atc_pkg::ADDR_TONE
        ##1 1'b1 |-> tone_generator_control == $past(rx_byte)
        && $stable(audio_path_select))
        else $error("tone register write wrong");

    freq_write_a: assert property (
        wr_commit && addr_q == atc_pkg::ADDR_FREQ1
        |=> first_freq_word == $past(rx_byte) [*1] ##1 $stable(tone_freq_one)
        || !cs_b)
        else $error("first frequency word not held");

    power_bit_a: assert property (
        instr_done |=> power_down == $past(rx_byte[7]))
        else $error("power bit not applied");

    read_only_a: assert property (
        instr_done && rx_byte[2] |=> $stable(audio_path_select)
        && $stable(tone_freq_two) && state == atc_pkg::ATC_DATA_RD
        || state == atc_pkg::ATC_DONE)
        else $error("read instruction disturbed the bank");

    read_back_a: assert property (
        rd_load |=> shift_q == $past(read_val))
        else $error("read-back value not loaded");

    release_pin_a: assert property (
        cs_b |=> co_oe_b ##1 co_oe_b || !cs_b)
        else $error("data pin driven while deselected");

endmodule

`default_nettype wire

/* File: atc_host_model.sv */
// Purpose: host model driving the serial control port of the bank
// Assumes: clk is the bank clock; sclk is kept far slower than clk
// Notes:   drives ci as sclk falls, samples co late in the sclk high phase

`timescale 1ns/100ps
`default_nettype none

module atc_host_model
(
    // clock
    input  wire logic clk,
    // serial port
    output logic      sclk,
    output logic      cs_b,
    output logic      ci,
    input  wire logic co,
    input  wire logic co_oe_b
);
    logic [15:0] frm;

    // idle: deselected, serial clock parked low
    initial
    begin
        sclk = 1'b0;
        cs_b = 1'b1;
        ci   = 1'b0;
    end

    // data line wanders while deselected, so a stale level never helps
    always @(posedge clk)
        if (cs_b)
            ci <= ~ci;

    // one frame of nbits bits; rd collects co from the last eight
    task automatic xfer(input logic [7:0] ins, input logic [7:0] dat,
                        input int nbits, output logic [7:0] rd,
                        output logic oe);
        rd  = 8'h00;
        oe  = 1'b1;
        frm = {ins, dat};
        @(posedge clk);
        cs_b <= 1'b0;
        for (int i = 0; i < nbits; i++)
        begin
            @(posedge clk);
            sclk <= 1'b0;
            ci   <= frm[15 - i];
            repeat (2) @(posedge clk);
            sclk <= 1'b1;
            repeat (2) @(posedge clk);
            rd = {rd[6:0], co};
            oe = co_oe_b;
        end
        @(posedge clk);
        sclk <= 1'b0;
        cs_b <= 1'b1;
        repeat (3) @(posedge clk);
    endtask
endmodule

`default_nettype wire

/* File: atc_tone_ctrl_regs_tb_top.sv */
// Purpose: self-checking bench for the audio path and tone control bank
// Assumes: host model frames are the only way into the registers
// Notes:   outputs are compared after each frame has fully ended

`timescale 1ns/100ps
`default_nettype none

module atc_tone_ctrl_regs_tb_top;
    logic       clk, rst_b, sclk, cs_b, ci, co, co_oe_b, power_down;
    logic       tx_hi, tx_lo, side_on, rx_hi, rx_lo, ring_on, hpf_off, sig_on;
    logic [3:0] tx_g, side_g, ear_g, aux_g, tone_att;
    logic       first_sel, second_sel, sine, tone_tx;
    logic [7:0] first_word, second_word, rd;
    logic [7:0] ex [6];
    logic       oe;
    int         failures, checked, cycles;

    atc_tone_ctrl_regs atc_tone_ctrl_regs_inst (.clk(clk), .rst_b(rst_b),
        .sclk(sclk), .cs_b(cs_b), .ci(ci), .co(co), .co_oe_b(co_oe_b),
        .power_down(power_down), .tx_input_sel_hi(tx_hi),
        .tx_input_sel_lo(tx_lo), .sidetone_on(side_on),
        .rx_out_sel_hi(rx_hi), .rx_out_sel_lo(rx_lo),
        .ring_to_output_on(ring_on), .rx_highpass_bypass(hpf_off),
        .rx_signal_to_output_on(sig_on), .tx_amp_gain(tx_g),
        .sidetone_gain(side_g), .earpiece_gain(ear_g),
        .aux_amp_gain(aux_g), .tone_atten(tone_att),
        .first_freq_select(first_sel), .second_freq_select(second_sel),
        .sine_select(sine), .tone_into_tx(tone_tx),
        .first_freq_word(first_word), .second_freq_word(second_word));

    atc_host_model atc_host_model_inst (.clk(clk), .sclk(sclk),
        .cs_b(cs_b), .ci(ci), .co(co), .co_oe_b(co_oe_b));

    // 250 MHz clock
    initial
        clk = 1'b0;
    always #2 clk = ~clk;

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", checked, failures);
        if (failures == 0 && checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // hang guard: a full run needs well under 20000 cycles
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            failures++;
            $display("Error timeout expected end of run");
            report_and_stop();
        end
    end

    task automatic check(input string name, input logic [7:0] seen,
                         input logic [7:0] exp);
        checked++;
        if (seen !== exp)
        begin
            failures++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // write register i (offset from the path address), remember result
    task automatic put(input int i, input logic [7:0] d,
                       input logic [7:0] e);
        ex[i] = e;
        atc_host_model_inst.xfer({1'b0, 4'(atc_pkg::ADDR_PATH + i), 3'b010},
                                 d, 16, rd, oe);
    endtask

    // compare every field output, then read every register back
    task automatic chk_all();
        check("path", {tx_hi, tx_lo, side_on, rx_hi, rx_lo, ring_on, hpf_off,
              sig_on}, ex[0]);
        check("gain", {tx_g, side_g}, ex[1]);
        check("atten", {ear_g, aux_g}, ex[2]);
        check("tone", {tone_att, first_sel, second_sel, sine, tone_tx},
              ex[3]);
        check("freq one", first_word, ex[4]);
        check("freq two", second_word, ex[5]);
        for (int i = 0; i < 6; i++)
        begin
            atc_host_model_inst.xfer({1'b0,
                4'(atc_pkg::ADDR_PATH + i), 3'b110}, 8'h00, 16, rd, oe);
            check("readback", rd, ex[i]);
            check("co enable", {7'h00, oe}, 8'h00);
        end
    endtask

    initial
    begin
        rst_b = 1'b0;
        repeat (3) @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
        check("power down", {7'h00, power_down}, 8'h01);
        check("co off", {7'h00, co_oe_b}, 8'h01);
        for (int i = 0; i < 6; i++)
            ex[i] = 8'h00;
        chk_all();
        check("power down", {7'h00, power_down}, 8'h00);
        // asymmetric patterns expose a reversed bit order
        put(0, 8'hD5, 8'hD5);
        put(1, 8'h2F, 8'h2F);
        put(2, 8'hF1, 8'hF1);
        put(3, 8'h9B, 8'h9B);
        put(4, 8'hC4, 8'hC4);
        put(5, 8'h31, 8'h31);
        chk_all();
        // forbidden route code keeps the old route, rest is written
        put(0, 8'h9B, 8'h93);
        // every frequency selection code, waveform and injection both ways
        for (int k = 0; k < 4; k++)
        begin
            put(3, {4'h3, 2'(k), 2'(k)}, {4'h3, 2'(k), 2'(k)});
            check("tone", {tone_att, first_sel, second_sel, sine, tone_tx},
                  ex[3]);
        end
        // frame dropped after twelve bits writes nothing
        atc_host_model_inst.xfer({1'b0, atc_pkg::ADDR_FREQ1, 3'b010},
                                 8'h00, 12, rd, oe);
        check("freq one", first_word, ex[4]);
        // unmapped places: write ignored, read gives zero
        atc_host_model_inst.xfer(8'h12, 8'hFF, 16, rd, oe);
        atc_host_model_inst.xfer(8'h5E, 8'h00, 16, rd, oe);
        check("unmapped", rd, 8'h00);
        check("co off", {7'h00, co_oe_b}, 8'h01);
        // single-byte instruction with the power bit set
        atc_host_model_inst.xfer({1'b1, atc_pkg::ADDR_PATH, 3'b000},
                                 8'h00, 8, rd, oe);
        check("power down", {7'h00, power_down}, 8'h01);
        chk_all();
        check("power down", {7'h00, power_down}, 8'h00);
        report_and_stop();
    end
endmodule

`default_nettype wire
